/* File: core/npr_burst_match.sv */
module npr_burst_match
    import npr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        an_restart,
    input  wire logic        cw_valid,
    input  wire logic [15:0] cw_data,
    output logic             cw_accept,
    output logic             ack_ok
);
    import npr_pkg::*;

    logic [15:0] last_reg;
    logic [1:0]  cnt_reg;
    logic [1:0]  cnt_next;
    logic        ack_reg;
    logic        ack_next;
    wire  [15:0] cw_masked;
    wire         same;
    wire         at_max;

    // The acknowledge bit is masked so the partner raising it does not restart the count.
    assign cw_masked = cw_data & NPR_CMP_MASK;
    assign same      = (cw_masked == last_reg) && (cnt_reg != 2'h0);
    assign at_max    = (cnt_reg == NPR_BURSTS);
    assign cnt_next  = an_restart ? 2'h0 :
                       !cw_valid  ? cnt_reg :
                       !same      ? 2'h1 :
                       at_max     ? cnt_reg : cnt_reg + 2'h1;
    assign cw_accept = cw_valid && !an_restart && same && (cnt_reg == NPR_BURSTS - 2'h1);
    assign ack_next  = an_restart ? 1'b0 :
                       cw_valid   ? (cnt_next == NPR_BURSTS) : ack_reg;
    assign ack_ok    = ack_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_reg <= NPR_RESET_VAL;
            cnt_reg  <= 2'h0;
            ack_reg  <= 1'b0;
        end
        else
        begin
            if (cw_valid)
                last_reg <= cw_masked;
            cnt_reg <= cnt_next;
            ack_reg <= ack_next;
        end
    end

    a_accept_needs_run: assert property (@(posedge mclk) disable iff (!rst_b)
        cw_accept |-> cnt_reg == 2'h2 && (cw_data & NPR_CMP_MASK) == last_reg)
        else $error("codeword accepted without two matching bursts before it");

    a_ack_raise: assert property (@(posedge mclk) disable iff (!rst_b)
        cw_accept |=> ack_ok)
        else $error("acknowledge not raised after third consistent burst");

    a_ack_drop: assert property (@(posedge mclk) disable iff (!rst_b)
        (cw_valid && !an_restart && (cw_data & NPR_CMP_MASK) != last_reg) |=> !ack_ok)
        else $error("acknowledge kept after an inconsistent burst");

    a_ack_restart: assert property (@(posedge mclk) disable iff (!rst_b)
        an_restart |=> !ack_ok && cnt_reg == 2'h0)
        else $error("restart did not clear burst tracking");

endmodule : npr_burst_match

/* File: core/npr_np_receive.sv */
// How it works
// - Bit 15 shows partner next-page flag; one means more pages follow.
// - Bit 14 shows partner acknowledge, always taken from codeword bit D14.
// - Acknowledge asserted after three consecutive consistent bursts, ignoring acknowledge bit.
// - Bit 13 shows page type: one message page, zero unformatted page.
// - Bit 12 shows partner second acknowledge: one means can comply.
// - Toggle bit must be the complement of the previous codeword's toggle.
// - First next page toggle is the inverse of base page bit 11.
// - Bits 10 to 0 hold received message or unformatted code.
// - High byte appears at offset 0x10, low byte at offset 0x11.
module npr_np_receive
    import npr_pkg::*;
#(
    parameter logic [3:0] PORT_NUM = NPR_PORT_DEF
)
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        an_restart,
    input  wire logic        cw_valid,
    input  wire logic [15:0] cw_data,
    input  wire logic        cw_is_next,
    input  wire logic [2:0]  ind_table_sel,
    input  wire logic [3:0]  ind_port,
    input  wire logic [7:0]  ind_offset,
    output logic      [7:0]  ind_data,
    output logic             ind_hit,
    output logic             local_ack,
    output logic      [15:0] np_status,
    output logic             toggle_err
);
    import npr_pkg::*;

    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic        exp_tog_reg;
    logic        exp_tog_next;
    logic        tog_err_reg;
    logic        tog_err_next;
    logic [7:0]  ind_data_reg;
    logic [7:0]  ind_data_next;
    logic        ind_hit_reg;
    logic        cw_accept;
    logic        ack_ok;
    wire         take_np;
    wire         take_base;
    wire         sel_ok;
    wire         sel_hi;
    wire         sel_lo;

    npr_burst_match u_match (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .an_restart (an_restart),
        .cw_valid   (cw_valid),
        .cw_data    (cw_data),
        .cw_accept  (cw_accept),
        .ack_ok     (ack_ok)
    );

    assign local_ack = ack_ok;

    assign take_np   = cw_accept && cw_is_next;
    assign take_base = cw_accept && !cw_is_next;

    // The whole codeword lands in place, so each flag keeps its codeword position.
    // There is no write path at all; software can only read this register.
    assign status_next = take_np ? cw_data : status_reg;

    // The expected toggle is seeded from the base page and then set to the inverse of each accepted page's toggle.
    assign exp_tog_next = cw_accept ? ~cw_data[NPR_BIT_TOG] : exp_tog_reg;
    assign tog_err_next = an_restart ? 1'b0 :
                          take_np    ? (cw_data[NPR_BIT_TOG] != exp_tog_reg) :
                          tog_err_reg;

    assign sel_ok = (ind_table_sel == NPR_TABLE_EEE) && (ind_port == PORT_NUM);
    assign sel_hi = sel_ok && (ind_offset == NPR_OFF_HI);
    assign sel_lo = sel_ok && (ind_offset == NPR_OFF_LO);
    assign ind_data_next = sel_hi ? status_reg[15:8] :
                           sel_lo ? status_reg[7:0]  : 8'h00;

    assign np_status  = status_reg;
    assign toggle_err = tog_err_reg;
    assign ind_data   = ind_data_reg;
    assign ind_hit    = ind_hit_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_reg   <= NPR_RESET_VAL;
            exp_tog_reg  <= 1'b0;
            tog_err_reg  <= 1'b0;
            ind_data_reg <= 8'h00;
            ind_hit_reg  <= 1'b0;
        end
        else
        begin
            status_reg   <= status_next;
            exp_tog_reg  <= exp_tog_next;
            tog_err_reg  <= tog_err_next;
            ind_data_reg <= ind_data_next;
            ind_hit_reg  <= sel_hi || sel_lo;
        end
    end

    sequence s_np_taken;
        take_np;
    endsequence

    sequence s_fields_landed;
        np_status == $past(cw_data);
    endsequence

    a_np_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        s_np_taken |=> s_fields_landed)
        else $error("next page codeword not captured");

    a_flags_kept: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[15:12] == $past(cw_data[15:12]))
        else $error("next page flags misplaced");

    a_status_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !take_np |=> $stable(np_status))
        else $error("status changed without an accepted next page");

    a_base_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
        take_base |=> np_status == $past(np_status))
        else $error("base page overwrote next page status");

    a_toggle_seed: assert property (@(posedge mclk) disable iff (!rst_b)
        take_base |=> exp_tog_reg == !$past(cw_data[NPR_BIT_TOG]))
        else $error("first next page toggle not seeded from base page");

    a_toggle_check: assert property (@(posedge mclk) disable iff (!rst_b)
        (take_np && !an_restart) |=> toggle_err == ($past(cw_data[NPR_BIT_TOG]) == $past(~exp_tog_reg)))
        else $error("toggle error flag wrong");

    a_ind_hi_byte: assert property (@(posedge mclk) disable iff (!rst_b)
        (sel_hi && !take_np) ##1 1'b1 |-> ind_hit && ind_data == np_status[15:8])
        else $error("high byte not presented at its offset");

    a_ind_lo_byte: assert property (@(posedge mclk) disable iff (!rst_b)
        (sel_lo && !take_np) |=> ind_hit && ind_data == np_status[7:0])
        else $error("low byte not presented at its offset");

    a_ind_miss: assert property (@(posedge mclk) disable iff (!rst_b)
        !(sel_hi || sel_lo) |=> !ind_hit && ind_data == 8'h00)
        else $error("unselected indirect read returned data");

    sequence s_restart;
        an_restart;
    endsequence

    sequence s_quiet;
        !take_np && !an_restart;
    endsequence

    sequence s_any_sel;
        sel_hi || sel_lo;
    endsequence

    // Each field is checked on its own so a misplaced bit points at the rule it breaks.
    a_np_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_BIT_NP] == $past(cw_data[NPR_BIT_NP]))
        else $error("next page flag not in bit 15");

    a_ack_bit: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_BIT_ACK] == $past(cw_data[NPR_BIT_ACK]))
        else $error("acknowledge flag not taken from codeword bit 14");

    a_page_type: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_BIT_MP] == $past(cw_data[NPR_BIT_MP]))
        else $error("page type flag not in bit 13");

    a_ack2_bit: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_BIT_ACK2] == $past(cw_data[NPR_BIT_ACK2]))
        else $error("second acknowledge flag not in bit 12");

    a_toggle_bit: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_BIT_TOG] == $past(cw_data[NPR_BIT_TOG]))
        else $error("toggle flag not in bit 11");

    a_code_field: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> np_status[NPR_CODE_MSB:NPR_CODE_LSB] ==
                    $past(cw_data[NPR_CODE_MSB:NPR_CODE_LSB]))
        else $error("code field not in bits 10 to 0");

    a_restart_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        s_restart |=> !toggle_err)
        else $error("restart did not clear the toggle error");

    a_err_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        s_quiet |=> $stable(toggle_err))
        else $error("toggle error changed without a next page");

    a_seed_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !cw_accept |=> $stable(exp_tog_reg))
        else $error("expected toggle moved without an accepted page");

    a_base_no_err: assert property (@(posedge mclk) disable iff (!rst_b)
        take_base |=> $stable(toggle_err))
        else $error("base page changed the toggle error");

    // This one runs without the reset guard, since it watches the release itself.
    a_reset_zero: assert property (@(posedge mclk)
        $rose(rst_b) |-> np_status == NPR_RESET_VAL && !toggle_err && !local_ack)
        else $error("outputs not cleared when reset is released");

    a_hit_on_sel: assert property (@(posedge mclk) disable iff (!rst_b)
        s_any_sel |=> ind_hit)
        else $error("selected offset gave no hit");

    a_hit_needs_sel: assert property (@(posedge mclk) disable iff (!rst_b)
        ind_hit |-> $past(sel_hi || sel_lo))
        else $error("hit without a matching select");

    a_table_port: assert property (@(posedge mclk) disable iff (!rst_b)
        (ind_table_sel != NPR_TABLE_EEE || ind_port != PORT_NUM) |=> !ind_hit)
        else $error("hit on wrong table or port");

    a_ack_held: assert property (@(posedge mclk) disable iff (!rst_b)
        (!cw_valid && !an_restart) |=> $stable(local_ack))
        else $error("acknowledge moved without a codeword");

    a_no_double_take: assert property (@(posedge mclk) disable iff (!rst_b)
        take_np |=> !take_np)
        else $error("repeated codeword accepted twice");

endmodule : npr_np_receive

/* File: core/npr_pkg.sv */
package npr_pkg;

    localparam int unsigned NPR_W         = 16;
    localparam int unsigned NPR_BIT_NP    = 15;
    localparam int unsigned NPR_BIT_ACK   = 14;
    localparam int unsigned NPR_BIT_MP    = 13;
    localparam int unsigned NPR_BIT_ACK2  = 12;
    localparam int unsigned NPR_BIT_TOG   = 11;
    localparam int unsigned NPR_CODE_MSB  = 10;
    localparam int unsigned NPR_CODE_LSB  = 0;

    localparam logic [15:0] NPR_RESET_VAL = 16'h0000;
    localparam logic [15:0] NPR_CMP_MASK  = 16'hbfff;

    localparam logic [2:0]  NPR_TABLE_EEE = 3'h1;
    localparam logic [7:0]  NPR_OFF_HI    = 8'h10;
    localparam logic [7:0]  NPR_OFF_LO    = 8'h11;
    localparam logic [3:0]  NPR_PORT_DEF  = 4'h1;

    localparam logic [1:0]  NPR_BURSTS    = 2'h3;

endpackage : npr_pkg

/* File: sim/npr_lp_model.sv */
module npr_lp_model (
    input  wire logic        mclk,
    output logic             cw_valid,
    output logic      [15:0] cw_data,
    output logic             cw_is_next
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_tog = 1'b0;
    initial
    begin
        cw_valid = 1'b0;
        cw_data = 16'h0000;
        cw_is_next = 1'b0;
    end
    // Three equal bursts make a consistent page; fewer are a fault unless the next call's bursts complete the run.
    task automatic send(input logic [15:0] cw, input logic nxt, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            cw_valid <= 1'b1;
            cw_data <= cw;
            cw_is_next <= nxt;
        end
        @(posedge mclk);
        cw_valid <= 1'b0;
        cw_data <= ~cw;
        cw_is_next <= ~nxt;
        if (n >= 3)
            last_tog = cw[11];
        @(posedge mclk);
        #1;
    endtask : send
    // Toggle is the complement of the last exchanged one unless a fault is asked.
    task automatic send_np(input logic [15:0] body, input logic good, output logic [15:0] cw);
        cw = body;
        cw[11] = good ? ~last_tog : last_tog;
        send(cw, 1'b1, 3);
    endtask : send_np
endmodule : npr_lp_model

/* File: sim/npr_np_receive_tb_top.sv */
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h seen %h", nm, e, g); end \
    end
module npr_np_receive_tb_top import npr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] PORT = 4'h2;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        an_restart = 1'b0;
    logic        cw_valid, cw_is_next, ind_hit, local_ack, toggle_err;
    logic [15:0] cw_data, np_status, cw_a;
    logic [2:0]  ind_table_sel = 3'h0;
    logic [3:0]  ind_port = 4'h0;
    logic [7:0]  ind_offset = 8'h00;
    logic [7:0]  ind_data;
    int          fails = 0;
    int          n_checks = 0;
    always #20 mclk = ~mclk;
    npr_lp_model lp_u (.mclk(mclk), .cw_valid(cw_valid), .cw_data(cw_data),
                       .cw_is_next(cw_is_next));
    npr_np_receive #(.PORT_NUM(PORT)) dut_u (.mclk(mclk), .rst_b(rst_b),
        .an_restart(an_restart), .cw_valid(cw_valid), .cw_data(cw_data),
        .cw_is_next(cw_is_next), .ind_table_sel(ind_table_sel), .ind_port(ind_port),
        .ind_offset(ind_offset), .ind_data(ind_data), .ind_hit(ind_hit),
        .local_ack(local_ack), .np_status(np_status), .toggle_err(toggle_err));
    task automatic rd(input logic [2:0] t, input logic [3:0] p, input logic [7:0] o,
                      input logic hit, input logic [7:0] exp);
        @(posedge mclk);
        ind_table_sel <= t;
        ind_port <= p;
        ind_offset <= o;
        @(posedge mclk);
        #1;
        `CHK("ind_hit", hit, ind_hit)
        `CHK("ind_data", exp, ind_data)
    endtask : rd
    task automatic t_reset;
        `CHK("np_status", 16'h0000, np_status)
        rd(NPR_TABLE_EEE, PORT, NPR_OFF_HI, 1'b1, 8'h00);
        rd(NPR_TABLE_EEE, PORT, NPR_OFF_LO, 1'b1, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_accept;
        lp_u.send(16'h0800, 1'b0, 3);
        `CHK("np_status", 16'h0000, np_status)
        `CHK("local_ack", 1'b1, local_ack)
        lp_u.send_np(16'hb2a5, 1'b1, cw_a);
        `CHK("np_status", 16'hb2a5, np_status)
        `CHK("toggle_err", 1'b0, toggle_err)
        rd(NPR_TABLE_EEE, PORT, NPR_OFF_HI, 1'b1, 8'hb2);
        rd(NPR_TABLE_EEE, PORT, NPR_OFF_LO, 1'b1, 8'ha5);
        $display("test accept done");
    endtask : t_accept
    task automatic t_partial;
        lp_u.send(16'h4123, 1'b1, 2);
        `CHK("np_status", 16'hb2a5, np_status)
        `CHK("local_ack", 1'b0, local_ack)
        $display("test partial done");
    endtask : t_partial
    task automatic t_toggle;
        lp_u.send_np(16'h0155, 1'b1, cw_a);
        `CHK("np_status", 16'h0955, np_status)
        `CHK("toggle_err", 1'b0, toggle_err)
        lp_u.send_np(16'h2000, 1'b0, cw_a);
        `CHK("np_status", 16'h2800, np_status)
        `CHK("toggle_err", 1'b1, toggle_err)
        @(posedge mclk);
        an_restart <= 1'b1;
        @(posedge mclk);
        an_restart <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK("toggle_err", 1'b0, toggle_err)
        `CHK("local_ack", 1'b0, local_ack)
        $display("test toggle done");
    endtask : t_toggle
    task automatic t_select;
        rd(3'h2, PORT, NPR_OFF_HI, 1'b0, 8'h00);
        rd(NPR_TABLE_EEE, 4'h3, NPR_OFF_HI, 1'b0, 8'h00);
        rd(NPR_TABLE_EEE, PORT, 8'h12, 1'b0, 8'h00);
        $display("test select done");
    endtask : t_select
    task automatic t_ack;
        lp_u.send(16'h1034, 1'b1, 2);
        lp_u.send(16'h5034, 1'b1, 1);
        `CHK("np_status", 16'h5034, np_status)
        $display("test ack done");
    endtask : t_ack
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        t_reset();
        t_accept();
        t_partial();
        t_toggle();
        t_select();
        t_ack();
        finish_test();
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        fails++;
        finish_test();
    end
endmodule : npr_np_receive_tb_top
